// file: core/leb_pkg.sv
// shared constants for the led effect serial register bank
package leb_pkg;
  localparam logic [6:0] LEB_ADDR_HI       = 7'h19;   // 11001 in the low five bits
  localparam int         LEB_ADDR_HI_W     = 5;
  localparam logic [7:0] LEB_OFF_SHUTDOWN  = 8'h00;
  localparam logic [7:0] LEB_OFF_CHAN_EN   = 8'h01;
  localparam logic [7:0] LEB_OFF_MODE      = 8'h03;
  localparam logic [7:0] LEB_OFF_DRIVE     = 8'h04;
  localparam logic [7:0] LEB_OFF_RAMP      = 8'h05;
  localparam logic [7:0] LEB_OFF_MARKER    = 8'h06;
  localparam logic [7:0] LEB_OFF_DUTY1     = 8'h07;
  localparam logic [7:0] LEB_OFF_DUTY6     = 8'h0C;
  localparam logic [7:0] LEB_OFF_DUTY_CMT  = 8'h10;
  localparam logic [7:0] LEB_OFF_DELAY1    = 8'h11;
  localparam logic [7:0] LEB_OFF_DELAY6    = 8'h16;
  localparam logic [7:0] LEB_OFF_RTIME1    = 8'h1A;
  localparam logic [7:0] LEB_OFF_RTIME2    = 8'h1B;
  localparam logic [7:0] LEB_OFF_OFFT1     = 8'h1D;
  localparam logic [7:0] LEB_OFF_OFFT6     = 8'h22;
  localparam logic [7:0] LEB_OFF_TIME_CMT  = 8'h26;
  localparam logic [7:0] LEB_OFF_RESET     = 8'hFF;
  localparam logic [7:0] LEB_COMMIT_VALUE  = 8'h00;
  localparam logic [7:0] LEB_RST_SHUTDOWN  = 8'h00;
  localparam logic [7:0] LEB_RST_CHAN_EN   = 8'h77;
  localparam logic [7:0] LEB_RST_ZERO      = 8'h00;
  localparam logic [7:0] LEB_MASK_SHUTDOWN = 8'h01;
  localparam logic [7:0] LEB_MASK_CHAN_EN  = 8'h77;
  localparam logic [7:0] LEB_MASK_MODE     = 8'h37;
  localparam logic [7:0] LEB_MASK_DRIVE    = 8'hF7;
  localparam logic [7:0] LEB_MASK_RAMP     = 8'h33;
  localparam logic [7:0] LEB_MASK_MARKER   = 8'h17;
  localparam logic [7:0] LEB_MASK_DELAY    = 8'h3F;
  localparam logic [7:0] LEB_MASK_RTIME    = 8'hF7;
  localparam logic [7:0] LEB_MASK_OFFT     = 8'h3F;
  localparam logic [2:0] LEB_MARKER_MAX    = 3'h5;
  localparam int         LEB_CHANNELS      = 6;
  localparam int         LEB_GROUPS        = 2;
  typedef enum logic [2:0] {
    LEB_IDLE  = 3'b000,
    LEB_SHIFT = 3'b001,
    LEB_ACK   = 3'b010,
    LEB_WAIT  = 3'b011,
    LEB_IGN   = 3'b100
  } leb_state_t;
endpackage

// file: core/leb_register_bank.sv
// two-wire write-only slave and control register bank of the led driver
//
// Functional notes
// R1 - master shifts address msb first, stable high
// R2 - master releases data for acknowledge clock
// R3 - own address acknowledged by holding data low
// R4 - master stops on missing address acknowledge
// R5 - register address byte sent and acknowledged
// R6 - one data byte sent and acknowledged
// R7 - stop condition ends each transfer
// R8 - shutdown bit zero means off, resets zero
// R9 - per-output enable bits, reset to 111
// R10 - audio modulation enable bit D2
// R11 - gain control disable bit D1, inverted
// R12 - gain control rate select bit D0
// R13 - sync role bit D7, follower when set
// R14 - current code D6:D4, audio gain D2:D0
// R15 - ramp enable D5:D4, hold select D1:D0
// R16 - hold select picks T2 or T4 stop
// R17 - marker enable D4, channel code D2:D0
// R18 - six duty registers scale max current
// R19 - duty and enable staged until commit zero
// R20 - start delay multiplier D3:D0, exponent D5:D4
// R21 - doubling flag, hold and rise exponents
// R22 - time commit moves staged times active
// R23 - reset register write restores all defaults
// R24 - address 11001, strap bits, write only
// R25 - group mode: direct duty or one-shot
// R26 - doubling flag doubles fall; rise coding
// R27 - hold code coding, zero gives none
`timescale 1ns/10ps
`default_nettype none
module leb_register_bank
  import leb_pkg::*;
(
  input  wire logic        clk_sys_i,        // system clock, 125 MHz
  input  wire logic        rst_n_i,          // synchronous reset, low
  input  wire logic        scl_i,            // serial clock pin
  input  wire logic        sda_i,            // serial data pin level
  output logic             sda_o,            // data drive value, always 0
  output logic             sda_oe_o,         // data pull-low enable
  input  wire logic [1:0]  addr_strap_i,     // address strap bits
  output logic             soft_off_n_o,     // 1 normal, 0 shutdown
  output logic [5:0]       channel_on_o,     // active channel enables
  output logic [1:0]       group_program_mode_o, // 1 one-shot breathing
  output logic             sound_drive_en_o, // audio modulation enable
  output logic             auto_gain_off_o,  // 1 disables gain control
  output logic             auto_gain_rate_o, // 1 slow modulation
  output logic             sync_role_o,      // 1 follower
  output logic [2:0]       current_code_o,   // max current code
  output logic [2:0]       sound_gain_o,     // gain, 3 dB steps
  output logic [1:0]       ramp_en_o,        // per-group ramp enable
  output logic [1:0]       hold_phase_o,     // 0 hold T2, 1 hold T4
  output logic             phase_marker_en_o, // marker enabled, valid
  output logic [2:0]       marker_channel_o, // marked output code
  output logic [47:0]      duty_o,           // active duty, out1 low
  output logic [35:0]      start_delay_o,    // active delays, 6 bits each
  output logic [15:0]      ramp_times_o,     // active group time fields
  output logic [35:0]      off_time_o,       // active off times
  output logic             time_load_o       // pulse on time commit
);
  // pin synchronisers and sampled levels
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_q, sda_q;
  logic [1:0] strap_s1_q, strap_s2_q;
  always_ff @(posedge clk_sys_i) begin
    scl_sync_q <= {scl_sync_q[0], scl_i};
    sda_sync_q <= {sda_sync_q[0], sda_i};
    scl_q      <= scl_sync_q[1];
    sda_q      <= sda_sync_q[1];
    strap_s1_q <= addr_strap_i;
    strap_s2_q <= strap_s1_q;
  end
  wire scl_rise = scl_sync_q[1] & ~scl_q;
  wire scl_fall = ~scl_sync_q[1] & scl_q;
  wire start_c  = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  wire stop_c   = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1]; // [R7]

  leb_state_t state_q, state_d;
  logic [7:0] shift_q;
  logic [2:0] bitcnt_q;
  logic [1:0] byte_q;
  logic [7:0] regaddr_q;
  logic       ack_q;
  logic       ackdone_q;
  wire [7:0]  byte_in = {shift_q[6:0], sda_sync_q[1]};
  // address match: 11001, strap, write bit 0
  wire addr_ok = (byte_in[7:3] == LEB_ADDR_HI[LEB_ADDR_HI_W-1:0]) &&
                 (byte_in[2:1] == strap_s2_q) && !byte_in[0]; // [R24]
  wire last_bit = (bitcnt_q == 3'h7);
  wire take_ok  = (state_q == LEB_SHIFT) && scl_rise && last_bit &&
                  ((byte_q != 2'h0) || addr_ok);
  wire ack_end  = (state_q == LEB_ACK) && scl_fall && ackdone_q;
  wire data_wr  = ack_end && (byte_q == 2'h2);    // [R6]

  always_comb begin
    state_d = state_q;
    case (state_q)
      LEB_IDLE:  state_d = LEB_IDLE;
      LEB_SHIFT: begin
        if (scl_rise && last_bit) begin
          state_d = take_ok ? LEB_WAIT : LEB_IGN;
        end
      end
      LEB_WAIT:  if (scl_fall) state_d = LEB_ACK;
      LEB_ACK:   if (ack_end) state_d = (byte_q == 2'h2) ? LEB_IGN : LEB_SHIFT;
      LEB_IGN:   state_d = LEB_IGN;
      default:   state_d = LEB_IDLE;
    endcase
    if (start_c) state_d = LEB_SHIFT;
    if (stop_c)  state_d = LEB_IDLE;              // [R4] [R7]
  end

  // byte framing: a start restarts from the address byte
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q  <= LEB_IDLE;
      shift_q  <= 8'h00;
      bitcnt_q <= 3'h0;
      byte_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      if (start_c) begin
        bitcnt_q <= 3'h0;
        byte_q   <= 2'h0;
      end else begin
        if (state_q == LEB_SHIFT && scl_rise) begin
          shift_q  <= byte_in;                    // [R1] [R5] [R6]
          bitcnt_q <= bitcnt_q + 3'h1;
        end
        if (ack_end) byte_q <= byte_q + 2'h1;
      end
    end
  end

  // acknowledge drive: raised after the eighth bit, dropped after the pulse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      regaddr_q <= 8'h00;
      ack_q     <= 1'b0;
      ackdone_q <= 1'b0;
    end else begin
      if (state_q == LEB_WAIT && scl_fall) begin
        ack_q     <= 1'b1;                        // [R2] [R3]
        ackdone_q <= 1'b0;
        if (byte_q == 2'h1) regaddr_q <= shift_q; // [R5]
      end
      if (state_q == LEB_ACK && scl_rise) ackdone_q <= 1'b1;
      if (ack_end || stop_c || start_c) ack_q <= 1'b0;
    end
  end

  // register write decode
  wire [7:0] wd = shift_q;
  wire wr_rst   = data_wr && regaddr_q == LEB_OFF_RESET &&
                  wd == LEB_COMMIT_VALUE;         // [R23]
  wire wr_shd   = data_wr && regaddr_q == LEB_OFF_SHUTDOWN;
  wire wr_en    = data_wr && regaddr_q == LEB_OFF_CHAN_EN;
  wire wr_mode  = data_wr && regaddr_q == LEB_OFF_MODE;
  wire wr_drv   = data_wr && regaddr_q == LEB_OFF_DRIVE;
  wire wr_ramp  = data_wr && regaddr_q == LEB_OFF_RAMP;
  wire wr_mark  = data_wr && regaddr_q == LEB_OFF_MARKER;
  wire duty_cmt = data_wr && regaddr_q == LEB_OFF_DUTY_CMT &&
                  wd == LEB_COMMIT_VALUE;         // [R19]
  wire time_cmt = data_wr && regaddr_q == LEB_OFF_TIME_CMT &&
                  wd == LEB_COMMIT_VALUE;         // [R22]
  wire [7:0] duty_idx  = regaddr_q - LEB_OFF_DUTY1;
  wire [7:0] delay_idx = regaddr_q - LEB_OFF_DELAY1;
  wire [7:0] offt_idx  = regaddr_q - LEB_OFF_OFFT1;
  wire wr_duty  = data_wr && regaddr_q >= LEB_OFF_DUTY1 &&
                  regaddr_q <= LEB_OFF_DUTY6;
  wire wr_delay = data_wr && regaddr_q >= LEB_OFF_DELAY1 &&
                  regaddr_q <= LEB_OFF_DELAY6;
  wire wr_rt1   = data_wr && regaddr_q == LEB_OFF_RTIME1;
  wire wr_rt2   = data_wr && regaddr_q == LEB_OFF_RTIME2;
  wire wr_offt  = data_wr && regaddr_q >= LEB_OFF_OFFT1 &&
                  regaddr_q <= LEB_OFF_OFFT6;
  wire clr      = !rst_n_i || wr_rst;

  logic [7:0] shd_q, mode_q, drv_q, ramp_q, mark_q;
  logic [7:0] en_stage_q, en_act_q;
  logic [7:0] duty_stage_q [LEB_CHANNELS];
  logic [7:0] duty_act_q   [LEB_CHANNELS];
  logic [7:0] dly_stage_q  [LEB_CHANNELS];
  logic [7:0] dly_act_q    [LEB_CHANNELS];
  logic [7:0] off_stage_q  [LEB_CHANNELS];
  logic [7:0] off_act_q    [LEB_CHANNELS];
  logic [7:0] rt_stage_q   [LEB_GROUPS];
  logic [7:0] rt_act_q     [LEB_GROUPS];
  logic       tload_q;

  // marker enable is kept off for codes with no output behind them
  wire       mark_code_ok = (wd[2:0] <= LEB_MARKER_MAX);
  wire [7:0] mark_wd      = (wd & LEB_MASK_MARKER) &
                            {3'h7, mark_code_ok, 4'hF}; // [R17]

  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      shd_q <= LEB_RST_SHUTDOWN;                  // [R8]
    end else if (wr_shd) begin
      shd_q <= wd & LEB_MASK_SHUTDOWN;            // [R8]
    end
  end

  // enable bits wait in the shadow copy for the duty commit
  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      en_stage_q <= LEB_RST_CHAN_EN;              // [R9]
      en_act_q   <= LEB_RST_CHAN_EN;
    end else begin
      if (wr_en) en_stage_q <= wd & LEB_MASK_CHAN_EN; // [R9] [R19]
      if (duty_cmt) en_act_q <= en_stage_q;       // [R19]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      mode_q <= LEB_RST_ZERO;                     // [R10] [R11]
    end else if (wr_mode) begin
      mode_q <= wd & LEB_MASK_MODE;  // [R10] [R11] [R12] [R25]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      drv_q <= LEB_RST_ZERO;
    end else if (wr_drv) begin
      drv_q <= wd & LEB_MASK_DRIVE;               // [R13] [R14]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      ramp_q <= LEB_RST_ZERO;                     // [R15]
    end else if (wr_ramp) begin
      ramp_q <= wd & LEB_MASK_RAMP;               // [R15] [R16]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      mark_q <= LEB_RST_ZERO;
    end else if (wr_mark) begin
      mark_q <= mark_wd;                          // [R17]
    end
  end

  // one-cycle strobe that tells the timing engine to reload
  always_ff @(posedge clk_sys_i) begin
    if (clr) begin
      tload_q <= 1'b0;
    end else begin
      tload_q <= time_cmt;                        // [R22]
    end
  end

  for (genvar i = 0; i < LEB_CHANNELS; i++) begin : g_ch
    always_ff @(posedge clk_sys_i) begin
      if (clr) begin
        duty_stage_q[i] <= LEB_RST_ZERO;          // [R18]
        duty_act_q[i]   <= LEB_RST_ZERO;
        dly_stage_q[i]  <= LEB_RST_ZERO;
        dly_act_q[i]    <= LEB_RST_ZERO;
        off_stage_q[i]  <= LEB_RST_ZERO;
        off_act_q[i]    <= LEB_RST_ZERO;
      end else begin
        if (wr_duty && duty_idx == 8'(i)) duty_stage_q[i] <= wd; // [R18]
        if (duty_cmt) duty_act_q[i] <= duty_stage_q[i];         // [R19]
        if (wr_delay && delay_idx == 8'(i)) begin
          dly_stage_q[i] <= wd & LEB_MASK_DELAY;  // [R20]
        end
        if (wr_offt && offt_idx == 8'(i)) begin
          off_stage_q[i] <= wd & LEB_MASK_OFFT;
        end
        if (time_cmt) begin
          dly_act_q[i] <= dly_stage_q[i];         // [R22]
          off_act_q[i] <= off_stage_q[i];
        end
      end
    end
    assign duty_o[8*i +: 8]        = duty_act_q[i];
    assign start_delay_o[6*i +: 6] = dly_act_q[i][5:0];
    assign off_time_o[6*i +: 6]    = off_act_q[i][5:0];
  end

  for (genvar g = 0; g < LEB_GROUPS; g++) begin : g_grp
    always_ff @(posedge clk_sys_i) begin
      if (clr) begin
        rt_stage_q[g] <= LEB_RST_ZERO;
        rt_act_q[g]   <= LEB_RST_ZERO;
      end else begin
        if ((g == 0 && wr_rt1) || (g == 1 && wr_rt2)) begin
          rt_stage_q[g] <= wd & LEB_MASK_RTIME;   // [R21] [R26] [R27]
        end
        if (time_cmt) rt_act_q[g] <= rt_stage_q[g]; // [R22]
      end
    end
    assign ramp_times_o[8*g +: 8] = rt_act_q[g];
  end

  assign sda_o                = 1'b0;
  assign sda_oe_o             = ack_q;              // [R3]
  assign soft_off_n_o         = shd_q[0];
  assign channel_on_o         = {en_act_q[6:4], en_act_q[2:0]};
  assign group_program_mode_o = mode_q[5:4];
  assign sound_drive_en_o     = mode_q[2];
  assign auto_gain_off_o      = mode_q[1];
  assign auto_gain_rate_o     = mode_q[0];
  assign sync_role_o          = drv_q[7];
  assign current_code_o       = drv_q[6:4];
  assign sound_gain_o         = drv_q[2:0];
  assign ramp_en_o            = ramp_q[5:4];
  assign hold_phase_o         = ramp_q[1:0];
  assign phase_marker_en_o    = mark_q[4];          // [R17]
  assign marker_channel_o     = mark_q[2:0];
  assign time_load_o          = tload_q;

  // steps of one acknowledged or refused byte
  sequence s_byte_taken;
    state_q == LEB_WAIT && scl_fall && !start_c && !stop_c;
  endsequence
  sequence s_pulse_over;
    ack_end && !start_c && !stop_c;
  endsequence
  sequence s_addr_refused;
    state_q == LEB_SHIFT && scl_rise && last_bit && byte_q == 2'h0 &&
    !addr_ok && !start_c && !stop_c;
  endsequence

  a_ack_on_match: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_byte_taken |=> sda_oe_o) // [R3]
    else $error("acknowledge not driven after match");

  a_ack_in_slot: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    state_q == LEB_ACK |-> sda_oe_o) // [R3]
    else $error("acknowledge dropped inside its pulse");

  a_ack_release: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_pulse_over |=> !sda_oe_o) // [R3] [R6]
    else $error("data line still held after the pulse");

  a_addr_refused: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_addr_refused |=> state_q == LEB_IGN && !sda_oe_o) // [R24]
    else $error("foreign address was not ignored");

  a_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state_q == LEB_IDLE || state_q == LEB_IGN) |-> !sda_oe_o) // [R24]
    else $error("data line held while not addressed");

  a_one_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ack_end && byte_q == 2'h2 && !start_c && !stop_c
    |=> state_q == LEB_IGN) // [R6]
    else $error("bytes after the data byte not ignored");

  // staged settings move only on their commit
  a_shadow_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_duty || wr_en) |=> $stable(duty_o) && $stable(channel_on_o)) // [R19]
    else $error("staged duty or enable reached the outputs");

  a_time_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_delay || wr_offt || wr_rt1 || wr_rt2) |=> $stable(start_delay_o) &&
    $stable(off_time_o) && $stable(ramp_times_o)) // [R22]
    else $error("staged time reached the outputs");

  a_marker_valid: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_marker_en_o |-> marker_channel_o <= LEB_MARKER_MAX) // [R17]
    else $error("marker enabled on a code with no output");

  a_commit_duty: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    duty_cmt && !wr_rst |=> duty_o[7:0] == $past(duty_stage_q[0])) // [R19]
    else $error("duty commit did not load");
  a_soft_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_rst |=> channel_on_o == 6'h3F && !soft_off_n_o) // [R23]
    else $error("soft reset did not restore defaults");
  a_time_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    time_cmt && !wr_rst |=> time_load_o &&
    ramp_times_o[7:0] == $past(rt_stage_q[0])) // [R22]
    else $error("time commit did not load");
endmodule
`default_nettype wire

// file: bench/leb_i2c_host.sv
// two-wire bus master model that programs the register bank
`timescale 1ns/10ps
`default_nettype none
module leb_i2c_host (
  input  wire logic clk_i,      // system clock
  input  wire logic sda_i,      // resolved data line level
  output logic      scl_o,      // serial clock, idles high
  output logic      sda_pull_o  // 1 pulls the data line low
);
  int half_q = 6;  // cycles per scl phase, raised for a slow host
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start();
    sda_pull_o = 1'b0;
    tick(half_q);
    sda_pull_o = 1'b1;
    tick(half_q);
    scl_o = 1'b0;
    tick(2);
  endtask
  // data changes only while the clock is low
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      sda_pull_o = ~b[i];
      tick(half_q);
      scl_o = 1'b1;
      tick(half_q);
      scl_o = 1'b0;
      tick(2);
    end
  endtask
  // released line; counts as ack only if low at both samples in the pulse
  task automatic ack_slot(output logic ack);
    sda_pull_o = 1'b0;
    tick(half_q);
    scl_o = 1'b1;
    tick(2);
    ack = ~sda_i;
    tick(half_q - 2);
    ack = ack & ~sda_i;
    scl_o = 1'b0;
    tick(2);
  endtask
  // data rises while the clock is high
  task automatic stop();
    sda_pull_o = 1'b1;
    tick(half_q);
    scl_o = 1'b1;
    tick(half_q);
    sda_pull_o = 1'b0;
    tick(half_q);
  endtask
endmodule
`default_nettype wire

// file: bench/leb_register_bank_test.sv
// self-checking bench for the led driver register bank
`timescale 1ns/10ps
`default_nettype none
module leb_register_bank_test;
  import leb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strap = 2'b00;
  logic scl, pull, sda_o, sda_oe, tload, soff, mk_en, sync;
  logic ae, ag_off, ag_rate;
  logic [1:0] gpm, ramp, hold;
  logic [2:0] cur, gain, mk_ch;
  logic [5:0] chan;
  logic [47:0] duty;
  logic [35:0] dly, offt;
  logic [15:0] rtime;
  logic [7:0] st [256];
  logic [7:0] ac [256];
  int fail_count = 0;
  int n_tests = 0;
  int loads = 0;
  wire logic sda_w = ~(pull | (sda_oe & ~sda_o));
  wire logic [7:0] own_w = {5'b11001, strap, 1'b0};
  always #4 clk = ~clk;
  always @(negedge clk) if (tload === 1'b1) loads++;
  leb_i2c_host host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_pull_o(pull));
  leb_register_bank dut (.clk_sys_i(clk), .rst_n_i(rst_n), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .addr_strap_i(strap), .soft_off_n_o(soff), .channel_on_o(chan),
    .group_program_mode_o(gpm), .sound_drive_en_o(ae),
    .auto_gain_off_o(ag_off), .auto_gain_rate_o(ag_rate),
    .sync_role_o(sync), .current_code_o(cur), .sound_gain_o(gain),
    .ramp_en_o(ramp), .hold_phase_o(hold), .phase_marker_en_o(mk_en),
    .marker_channel_o(mk_ch), .duty_o(duty), .start_delay_o(dly),
    .ramp_times_o(rtime), .off_time_o(offt), .time_load_o(tload));
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic mreset();
    for (int i = 0; i < 256; i++) begin
      st[i] = 8'h00;
      ac[i] = 8'h00;
    end
    st[1] = LEB_RST_CHAN_EN;
    ac[1] = LEB_RST_CHAN_EN;
  endtask
  task automatic apply(input logic [7:0] r, input logic [7:0] d);
    st[r] = d;
    if (r == 8'h00 || (r >= 8'h03 && r <= 8'h06)) ac[r] = d;
    if (d == 8'h00 && r == LEB_OFF_DUTY_CMT)
      for (int i = 1; i <= 12; i++) if (i == 1 || i >= 7) ac[i] = st[i];
    if (d == 8'h00 && r == LEB_OFF_TIME_CMT)
      for (int i = 17; i <= 34; i++) ac[i] = st[i];
    if (d == 8'h00 && r == LEB_OFF_RESET) mreset();
  endtask
  task automatic verify();
    logic [47:0] du;
    logic [35:0] dl, ot;
    for (int i = 0; i < 6; i++) begin
      du[i*8 +: 8] = ac[7+i];
      dl[i*6 +: 6] = ac[17+i][5:0];
      ot[i*6 +: 6] = ac[29+i][5:0];
    end
    chk(64'(soff), 64'(ac[0][0]));
    chk(64'(chan), {ac[1][6:4], ac[1][2:0]});
    chk({gpm, ae, ag_off, ag_rate}, {ac[3][5:4], ac[3][2:0]});
    chk({sync, cur, gain}, {ac[4][7:4], ac[4][2:0]});
    chk({ramp, hold}, {ac[5][5:4], ac[5][1:0]});
    chk({mk_en, mk_ch}, {ac[6][4] & (ac[6][2:0] <= 3'h5), ac[6][2:0]});
    chk(64'(duty), 64'(du));
    chk(64'(dly), 64'(dl));
    chk(64'(rtime), {ac[27] & 8'hF7, ac[26] & 8'hF7});
    chk(64'(offt), 64'(ot));
  endtask
  // mode 0 plain, 1 with a surplus byte, 2 stopped inside the data byte
  task automatic wr(input logic [7:0] ab, input logic [7:0] r,
                    input logic [7:0] d, input logic good, input int mode);
    logic k;
    int l0;
    l0 = loads;
    host.start();
    host.shift(ab, 8);
    host.ack_slot(k);
    chk(64'(k), 64'(good));
    if (k) begin
      host.shift(r, 8);
      host.ack_slot(k);
      chk(64'(k), 64'h1);
      if (mode == 2) host.shift(d, 4);
      else begin
        host.shift(d, 8);
        host.ack_slot(k);
        chk(64'(k), 64'h1);
      end
      if (mode == 1) begin
        host.shift(~d, 8);
        host.ack_slot(k);
        chk(64'(k), 64'h0);
      end
    end
    host.stop();
    if (good && mode != 2) apply(r, d);
    chk(64'(loads - l0), 64'(good && mode != 2 && d == 8'h00
        && r == LEB_OFF_TIME_CMT));
    verify();
  endtask
  initial begin
    for (int i = 0; i < 100000; i++) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    logic [7:0] cfg [5];
    cfg = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06};
    void'($urandom(92));
    strap = 2'($urandom);
    mreset();
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    verify();
    for (int i = 0; i < 20; i++) wr(own_w, cfg[i % 5], 8'($urandom), 1, 0);
    for (int c = 0; c < 8; c++)
      wr(own_w, LEB_OFF_MARKER, {3'($urandom), 2'b10, 3'(c)}, 1, 0);
    for (int i = 0; i < 7; i++)
      wr(own_w, i == 0 ? 8'h01 : 8'(6 + i), 8'($urandom), 1, 0);
    wr(own_w, LEB_OFF_DUTY_CMT, 8'h5A, 1, 0);
    wr(own_w, LEB_OFF_DUTY_CMT, 8'h00, 1, 0);
    host.half_q = 20;
    for (int i = 0; i < 14; i++)
      wr(own_w, i < 6 ? 8'(17 + i) : i < 8 ? 8'(20 + i) : 8'(21 + i),
         8'($urandom), 1, 0);
    wr(own_w, LEB_OFF_TIME_CMT, 8'h80, 1, 0);
    wr(own_w, LEB_OFF_TIME_CMT, 8'h00, 1, 0);
    host.half_q = 6;
    wr({5'b11001, ~strap, 1'b0}, 8'h00, 8'h01, 0, 0);
    wr({5'b11011, strap, 1'b0}, 8'h00, 8'h01, 0, 0);
    wr({5'b11001, strap, 1'b1}, 8'h00, 8'h01, 0, 0);
    wr(own_w, LEB_OFF_DRIVE, 8'($urandom), 1, 1);
    wr(own_w, LEB_OFF_SHUTDOWN, ~ac[0], 1, 2);
    wr(own_w, LEB_OFF_RESET, 8'h33, 1, 0);
    wr(own_w, LEB_OFF_RESET, 8'h00, 1, 0);
    wr(own_w, LEB_OFF_MODE, 8'($urandom), 1, 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    mreset();
    repeat (6) @(negedge clk);
    verify();
    conclude();
  end
endmodule
`default_nettype wire
